// *** capture_compare_pkg.sv ***
// Package for the dual capture/compare/PWM unit: register map, field layout,
// mode codes and reset values. Assumes a 32-bit APB slave on a word-aligned map.
package capture_compare_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_FLAGS_ONE    = 8'h0c;
  localparam logic [7:0] IDX_FLAGS_TWO    = 8'h0d;
  localparam logic [7:0] IDX_ENABLES_ONE  = 8'h8c;
  localparam logic [7:0] IDX_CAP_ONE_LOW  = 8'h15;
  localparam logic [7:0] IDX_CAP_ONE_HIGH = 8'h16;
  localparam logic [7:0] IDX_CTRL_ONE     = 8'h17;
  localparam logic [7:0] IDX_CAP_TWO_LOW  = 8'h1b;
  localparam logic [7:0] IDX_CAP_TWO_HIGH = 8'h1c;
  localparam logic [7:0] IDX_CTRL_TWO     = 8'h1d;

  // Flag bit positions
  localparam int FLAG_ONE_BIT = 2;
  localparam int FLAG_TWO_BIT = 0;

  // Reset values
  localparam logic [7:0]  FLAGS_RESET   = 8'h00;
  localparam logic [7:0]  ENABLES_RESET = 8'h00;
  localparam logic [5:0]  CTRL_RESET    = 6'h00;
  localparam logic [15:0] CAP_RESET     = 16'h0000;
  localparam logic [3:0]  PRESC_RESET   = 4'h0;

  // Mode field codes
  localparam logic [3:0] MODE_OFF        = 4'h0;
  localparam logic [3:0] MODE_CAP_FALL   = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE   = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4  = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET    = 4'h8;
  localparam logic [3:0] MODE_CMP_CLEAR  = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT   = 4'ha;
  localparam logic [3:0] MODE_CMP_TRIG   = 4'hb;

  // Prescaler terminal counts
  localparam logic [1:0] PRESC_LAST4  = 2'h3;
  localparam logic [3:0] PRESC_LAST16 = 4'hf;

  // Unit control register contents (bits 7:6 read as zero)
  typedef struct packed {
    logic [1:0] duty_low_bits;
    logic [3:0] mode_field;
  } unit_ctrl_s;

endpackage : capture_compare_pkg

// *** capture_compare_pwm_unit.sv ***
// Two capture/compare units with APB register access and Timer1 time base.
// Assumes timer1_count on pclk; unit pins arrive asynchronously from pads.
//
// What this block does
// - Selected pin event copies full 16-bit Timer1 count into capture value.
// - Modes 0100 falling, 0101 rising, 0110 every 4th, 0111 every 16th rise.
// - Mode 0000 disables the unit: pin output low, prescaler cleared, capture value kept.
// - Mode 1000 drives pin high, 1001 low on match; both set flag.
// - Mode 1010 match only sets the flag, pin untouched.
// - Mode 1011 sets flag, clears Timer1; unit two also starts enabled A/D.
// - Modes 11xx have no logic; control bits 5:4 only store two low duty bits.
// - Every capture sets the unit flag, which stays until software clears.
// - A newer capture overwrites an unread earlier value.
// - Pin driven as output still feeds edge detection, so port writes capture.
// - Mode change may set flag spuriously; software masks and clears it.
// - Prescaler clears when unit off, not capturing, or on reset.
// - Switching between capture prescales keeps the prescaler count.
// - Compare continuously; flag and pin action land in same cycle.
// - Each 16-bit value is two separately accessible byte registers.
// - Units identical except only unit two trigger starts A/D.
// - Both units share Timer1 as time base.
// - Special event clears Timer1 without setting the overflow flag.
`timescale 1ns/10ps

module capture_compare_pwm_unit
  import capture_compare_pkg::*;
#(
  parameter int UNITS = 2
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] timer1_count,
  input  wire logic        adc_enabled,
  input  wire logic [1:0]  unit_pin_in,
  output logic      [1:0]  unit_pin_out,
  output logic             timer1_clear,
  output logic             adc_start
);

  // Per-unit state
  unit_ctrl_s  ctrl      [UNITS];
  logic [15:0] cap       [UNITS];
  logic [3:0]  presc     [UNITS];
  logic        pin_meta  [UNITS];
  logic        pin_sync  [UNITS];
  logic        pin_prev  [UNITS];
  logic [UNITS-1:0] unit_set;
  logic [UNITS-1:0] unit_trig;

  // Shared registers
  logic [7:0]  flags_one;
  logic        flag_two;
  logic [7:0]  enables_one;

  // APB decode
  logic [9:0]  word_idx;
  logic        access;
  logic        wr_en;
  logic        hit_flags_one;
  logic        hit_flags_two;
  logic        hit_enables;
  logic [UNITS-1:0] hit_ctrl;
  logic [UNITS-1:0] hit_low;
  logic [UNITS-1:0] hit_high;
  logic        mapped;
  logic [7:0]  read_byte;

  assign word_idx      = paddr[11:2];
  assign access        = psel & penable & ~pready;
  assign wr_en         = psel & penable & pready & pwrite;
  assign hit_flags_one = word_idx == {2'b00, IDX_FLAGS_ONE};
  assign hit_flags_two = word_idx == {2'b00, IDX_FLAGS_TWO};
  assign hit_enables   = word_idx == {2'b00, IDX_ENABLES_ONE};
  assign hit_ctrl      = {word_idx == {2'b00, IDX_CTRL_TWO},
                          word_idx == {2'b00, IDX_CTRL_ONE}};
  assign hit_low       = {word_idx == {2'b00, IDX_CAP_TWO_LOW},
                          word_idx == {2'b00, IDX_CAP_ONE_LOW}};
  assign hit_high      = {word_idx == {2'b00, IDX_CAP_TWO_HIGH},
                          word_idx == {2'b00, IDX_CAP_ONE_HIGH}};
  assign mapped        = hit_flags_one | hit_flags_two | hit_enables |
                         (|hit_ctrl) | (|hit_low) | (|hit_high);

  // Read data selection
  assign read_byte =
      hit_flags_one ? flags_one :
      hit_flags_two ? {7'h00, flag_two} :
      hit_enables   ? enables_one :
      hit_ctrl[0]   ? {2'b00, ctrl[0]} :
      hit_ctrl[1]   ? {2'b00, ctrl[1]} :
      hit_low[0]    ? cap[0][7:0] :
      hit_low[1]    ? cap[1][7:0] :
      hit_high[0]   ? cap[0][15:8] :
      hit_high[1]   ? cap[1][15:8] : 8'h00;

  // APB answer: one wait cycle, then ready with data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= access;
      prdata  <= access ? {24'h00_0000, read_byte} : 32'h0000_0000;
      pslverr <= access & ~mapped;
    end
  end

  // Flag registers: hardware set beats software clear
  // Mode writes alone set a flag only through an immediate compare match
  logic [7:0] next_flags_one;
  logic       next_flag_two;
  always_comb begin
    next_flags_one = flags_one;
    next_flag_two  = flag_two;
    if (wr_en && hit_flags_one) next_flags_one = pwdata[7:0];
    if (wr_en && hit_flags_two) next_flag_two  = pwdata[FLAG_TWO_BIT];
    if (unit_set[0]) next_flags_one[FLAG_ONE_BIT] = 1'b1;
    if (unit_set[1]) next_flag_two = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_one   <= FLAGS_RESET;
      flag_two    <= 1'b0;
      enables_one <= ENABLES_RESET;
    end else begin
      flags_one   <= next_flags_one;
      flag_two    <= next_flag_two;
      enables_one <= (wr_en && hit_enables) ? pwdata[7:0] : enables_one;
    end
  end

  // Special event outputs; overflow flag is never touched here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer1_clear <= 1'b0;
      adc_start    <= 1'b0;
    end else begin
      timer1_clear <= |unit_trig;
      adc_start    <= unit_trig[1] & adc_enabled;
    end
  end

  // Identical per-unit logic
  genvar u;
  generate
    for (u = 0; u < UNITS; u++) begin : g_unit
      logic [3:0] mode;
      logic       is_off;
      logic       is_capture;
      logic       is_compare;
      logic       rise;
      logic       fall;
      logic       cap_event;
      logic       match;
      logic [3:0] next_presc;
      logic [15:0] next_cap;

      assign mode       = ctrl[u].mode_field;
      assign is_off     = mode == MODE_OFF;
      assign is_capture = mode[3:2] == 2'b01;
      assign is_compare = mode[3:2] == 2'b10;
      // Edges seen on the pad level, whether driven out or in
      assign rise       = pin_sync[u] & ~pin_prev[u];
      assign fall       = ~pin_sync[u] & pin_prev[u];

      // Event qualification per mode
      assign cap_event  = is_capture & (
          (mode == MODE_CAP_FALL) & fall |
          (mode == MODE_CAP_RISE) & rise |
          (mode == MODE_CAP_RISE4) & rise & (presc[u][1:0] == PRESC_LAST4) |
          (mode == MODE_CAP_RISE16) & rise & (presc[u] == PRESC_LAST16));

      // Compare against shared Timer1 every cycle
      assign match      = is_compare & (cap[u] == timer1_count);
      assign unit_set[u]  = cap_event | match;
      assign unit_trig[u] = match & (mode == MODE_CMP_TRIG);

      // Prescaler kept across capture modes, cleared otherwise
      assign next_presc = !is_capture ? PRESC_RESET :
                          rise ? presc[u] + 4'h1 : presc[u];

      // Capture value: pin capture wins over a same-cycle byte write
      always_comb begin
        next_cap = cap[u];
        if (wr_en && hit_low[u])  next_cap[7:0]  = pwdata[7:0];
        if (wr_en && hit_high[u]) next_cap[15:8] = pwdata[7:0];
        if (cap_event) next_cap = timer1_count;
      end

      // Pin synchronizer
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_meta[u] <= 1'b0;
          pin_sync[u] <= 1'b0;
          pin_prev[u] <= 1'b0;
        end else begin
          pin_meta[u] <= unit_pin_in[u];
          pin_sync[u] <= pin_meta[u];
          pin_prev[u] <= pin_sync[u];
        end
      end

      // Control, prescaler and capture registers
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctrl[u]  <= CTRL_RESET;
          presc[u] <= PRESC_RESET;
          cap[u]   <= CAP_RESET;
        end else begin
          ctrl[u]  <= (wr_en && hit_ctrl[u]) ? pwdata[5:0] : ctrl[u];
          presc[u] <= next_presc;
          cap[u]   <= next_cap;
        end
      end

      // Output latch: low while off, set or cleared on match
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          unit_pin_out[u] <= 1'b0;
        end else if (is_off) begin
          unit_pin_out[u] <= 1'b0;
        end else if (match && mode == MODE_CMP_SET) begin
          unit_pin_out[u] <= 1'b1;
        end else if (match && mode == MODE_CMP_CLEAR) begin
          unit_pin_out[u] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule : capture_compare_pwm_unit

// *** capture_compare_pwm_unit_tb.sv ***
// Testbench: APB master, Timer1 model, random capture and compare runs.
// Assumes the pin source model and the bound checker.
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end

module capture_compare_pwm_unit_tb
  import capture_compare_pkg::*;
;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic        pready, pslverr, timer1_clear, adc_start, e, adc_enabled = 0;
  logic        t1_load = 0, t1_run = 0;
  logic [15:0] timer1_count = '0, t1_val = '0;
  logic [1:0]  pin_req = '0, unit_pin_in, unit_pin_out;
  logic [7:0]  q;
  logic [7:0]  ctl [2] = '{IDX_CTRL_ONE, IDX_CTRL_TWO};
  logic [7:0]  lo [2] = '{IDX_CAP_ONE_LOW, IDX_CAP_TWO_LOW};
  logic [7:0]  hi [2] = '{IDX_CAP_ONE_HIGH, IDX_CAP_TWO_HIGH};
  logic [7:0]  flg [2] = '{IDX_FLAGS_ONE, IDX_FLAGS_TWO};
  logic [3:0]  cmode [4] = '{MODE_CMP_SET, MODE_CMP_SOFT, MODE_CMP_CLEAR, MODE_CMP_TRIG};
  logic        pexp [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  int          fails = 0, n_checks = 0, cycles = 0, n_clr = 0, n_adc = 0;

  always #4 pclk = ~pclk;

  // Timer1: loadable, stoppable, cleared by the trigger; runs on pclk
  always @(posedge pclk)
    if (t1_load) timer1_count <= t1_val;
    else if (timer1_clear) timer1_count <= 16'h0000;
    else if (t1_run) timer1_count <= timer1_count + 16'h0001;

  // Cycle limit and trigger pulse counts
  always @(posedge pclk) begin
    cycles++;
    n_clr += int'(timer1_clear);
    n_adc += int'(adc_start);
    if (cycles == 40000) begin
      fails++;
      print_verdict();
    end
  end

  capture_compare_pwm_unit uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .timer1_count, .adc_enabled, .unit_pin_in,
    .unit_pin_out, .timer1_clear, .adc_start);
  pin_source src (.level_req(pin_req), .unit_pin_in);

  task automatic print_verdict();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  // One APB transfer, held until ready is sampled
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pulse(input int u);
    pin_req[u] <= 1'b1;
    repeat (6) @(posedge pclk);
    pin_req[u] <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask : pulse

  task automatic set_t1(input logic [15:0] v, input logic run);
    t1_val  <= v;
    t1_load <= 1'b1;
    t1_run  <= run;
    @(posedge pclk);
    t1_load <= 1'b0;
  endtask : set_t1

  function automatic logic [7:0] fmask(input int u);
    return u ? (8'h01 << FLAG_TWO_BIT) : (8'h01 << FLAG_ONE_BIT);
  endfunction : fmask

  // Main sequence: reset values, captures, compares
  initial begin
    int u, m, n, k;
    logic [15:0] t, c;
    u = $urandom(35);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, IDX_ENABLES_ONE, 8'h00);
    `CHK(q, ENABLES_RESET)
    apb(1, IDX_CTRL_ONE, 8'hff);
    apb(0, IDX_CTRL_ONE, 8'h00);
    `CHK(q, 8'h3f)
    apb(0, 8'h3f, 8'h00);
    `CHK({e, q}, 9'h100)
    for (u = 0; u < 2; u++)
      for (m = 4; m < 8; m++) begin
        n = (m == 6) ? 4 : (m == 7) ? 16 : 1;
        apb(1, ctl[u], 8'h00);
        apb(1, flg[u], 8'h00);
        pulse(u);
        apb(0, flg[u], 8'h00);
        `CHK(q & fmask(u), 8'h00)
        apb(1, ctl[u], 8'(m));
        for (k = 0; k < 2 * n; k++) begin
          if (k == n - 1) begin
            apb(0, flg[u], 8'h00);
            `CHK(q & fmask(u), 8'h00)
          end
          t = 16'($urandom);
          set_t1(t, 1'b0);
          pulse(u);
        end
        apb(0, flg[u], 8'h00);
        `CHK(q & fmask(u), fmask(u))
        apb(0, lo[u], 8'h00);
        `CHK(q, t[7:0])
        apb(0, hi[u], 8'h00);
        `CHK(q, t[15:8])
      end
    for (u = 0; u < 2; u++) begin
      c = 16'h0100 + 16'($urandom % 32'he000);
      apb(1, ctl[u], 8'h00);
      apb(1, lo[u], c[7:0]);
      apb(1, hi[u], c[15:8]);
      `CHK(unit_pin_out[u], 1'b0)
      for (k = 0; k < 4; k++) begin
        adc_enabled <= 1'($urandom);
        apb(1, ctl[u], {4'h0, cmode[k]});
        apb(1, flg[u], 8'h00);
        n_clr = 0;
        n_adc = 0;
        set_t1(c - 16'h0008, 1'b1);
        repeat (24) @(posedge pclk);
        t1_run <= 1'b0;
        `CHK(unit_pin_out[u], pexp[k])
        `CHK(n_clr, (cmode[k] == MODE_CMP_TRIG) ? 1 : 0)
        `CHK(n_adc, (u == 1 && cmode[k] == MODE_CMP_TRIG && adc_enabled) ? 1 : 0)
        apb(0, flg[u], 8'h00);
        `CHK(q & fmask(u), fmask(u))
      end
    end
    print_verdict();
  end
endmodule : capture_compare_pwm_unit_tb

// *** capture_compare_sva.sv ***
// Checker for the capture/compare unit: APB answer timing, trigger outputs.
// Assumes it is bound onto the top module; one clock, async low reset.
`timescale 1ns/10ps

module capture_compare_sva
  import capture_compare_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        adc_enabled,
  input wire logic [1:0]  unit_pin_out,
  input wire logic        timer1_clear,
  input wire logic        adc_start
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Access still waiting, then the answer in the access phase
  sequence s_wait; psel && penable && !pready; endsequence
  sequence s_answer; pready && psel && penable; endsequence

  property p_one_wait; s_wait |=> s_answer; endproperty
  a_one_wait: assert property (p_one_wait) else $error("answer late");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_data_idle; !pready |-> prdata == 32'h00000000; endproperty
  a_data_idle: assert property (p_data_idle) else $error("read data not idle");
  property p_data_byte; pready |-> prdata[31:8] == 24'h000000; endproperty
  a_data_byte: assert property (p_data_byte) else $error("read beyond byte");
  property p_adc_clear; adc_start |-> timer1_clear; endproperty
  a_adc_clear: assert property (p_adc_clear) else $error("start without clear");
  property p_adc_en; adc_start |-> $past(adc_enabled); endproperty
  a_adc_en: assert property (p_adc_en) else $error("start while disabled");
  property p_quiet; $rose(presetn) |-> !timer1_clear && unit_pin_out == 2'b00; endproperty
  a_quiet: assert property (p_quiet) else $error("outputs after reset");
endmodule : capture_compare_sva

bind capture_compare_pwm_unit capture_compare_sva u_sva (
  .pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr,
  .adc_enabled, .unit_pin_out, .timer1_clear, .adc_start
);

// *** pin_source.sv ***
// Pin source model: external edge source on the two unit pins.
// Assumes the bench sets wanted pad levels; pads move off the clock edge.
`timescale 1ns/10ps

module pin_source (
  input  wire logic [1:0] level_req,
  output logic      [1:0] unit_pin_in
);
  // Pads follow the request after a board delay, pins kept as inputs
  assign #3 unit_pin_in = level_req;
endmodule : pin_source
